// *** hw/dual_temp_monitor_map.svh ***
// Behaviour
// - converter runs freely, alternating local and remote sensor measurements
// - each finished measurement lands in its value register as signed byte
// - sixteen raw samples of one channel are averaged before storing
// - one degree per code step, -128 to +127, minus one is all ones
// - stored results compared with both limits; a trip sets a flag and alert
// - software selects standby, alert masking and conversion rate
// - reads and writes use separate addresses; wrong-way access gives invalid result
// - first byte of each write loads the pointer, which targets later bytes
// - pointer resets to zero so a first read returns local value
// - only the converter updates the value registers; bus only reads them
// - status bit 7 is high while a conversion is running
// - status bits 6..3 hold local high, local low, remote high, remote low
// - status bit 2 is set when the remote sensor is open
// - any of the five flags sets the alert latch, pulling alert low
// - status read clears a flag only once its cause has gone
// - flags stay set until a status read or reset clears them
// - alert latch clears only on alert response with causes and flags gone
// - config bit 6 halts timed conversions but not one-shot ones, bit 7 masks alert; both reset low
// - high limit trips on greater than, low limit on less than
// - rate code low bits scale conversion period from 16 s to 125 ms
// - a write to 0F starts one conversion; the data is dropped
`ifndef DUAL_TEMP_MONITOR_MAP_SVH
`define DUAL_TEMP_MONITOR_MAP_SVH
`define ADDR_RD_LOCAL 8'h00
`define ADDR_RD_REMOTE 8'h01
`define ADDR_RD_STATUS 8'h02
`define ADDR_RD_CONFIG 8'h03
`define ADDR_RD_RATE 8'h04
`define ADDR_RD_LOCAL_HIGH 8'h05
`define ADDR_RD_LOCAL_LOW 8'h06
`define ADDR_RD_REMOTE_HIGH 8'h07
`define ADDR_RD_REMOTE_LOW 8'h08
`define ADDR_WR_CONFIG 8'h09
`define ADDR_WR_RATE 8'h0A
`define ADDR_WR_LOCAL_HIGH 8'h0B
`define ADDR_WR_LOCAL_LOW 8'h0C
`define ADDR_WR_REMOTE_HIGH 8'h0D
`define ADDR_WR_REMOTE_LOW 8'h0E
`define ADDR_WR_ONE_SHOT 8'h0F
`define ADDR_RD_MAKER_ID 8'hFE
`define ADDR_RD_DIE_REV 8'hFF
`define RESET_POINTER 8'h00
`define RESET_VALUE 8'h00
`define RESET_RATE 8'h02
`define RESET_HIGH_LIMIT 8'h7F
`define RESET_LOW_LIMIT 8'hC9
`define INVALID_READ 8'h00
`define STATUS_BUSY_BIT 7
`define STATUS_FLAG_LSB 2
`define CONFIG_MASK_BIT 7
`define CONFIG_STANDBY_BIT 6
`define AVG_SAMPLES_LOG2 4
`define RATE_CODE_MAX 3'h7
`define SYS_CLK_KHZ 40000
`define FASTEST_CONV_MS 125
`define FASTEST_CONV_CYCLES (`FASTEST_CONV_MS * `SYS_CLK_KHZ)
`endif

// *** hw/dual_temp_monitor_pkg.sv ***
package dual_temp_monitor_pkg;

    typedef enum logic [1:0] {st_idle, st_request, st_wait, st_settle} conv_state_e;

    typedef struct packed {
        logic signed [11:0] sum;
        logic [3:0] count;
        logic [7:0] average;
        logic valid;
    } avg_state_s;

    typedef struct packed {
        logic [7:0] pointer;
        logic [7:0] local_value;
        logic [7:0] remote_value;
        logic alarm_output_inhibit;
        logic standby;
        logic [7:0] rate;
        logic [7:0] local_high;
        logic [7:0] local_low;
        logic [7:0] remote_high;
        logic [7:0] remote_low;
        logic [4:0] flags;
        logic alert_latch;
        logic remote_open;
        logic open_seen;
        logic oneshot_pending;
        logic run_pending;
        logic busy;
        logic remote_sel;
        conv_state_e state;
        logic [31:0] timer;
        logic sample_request;
        logic [7:0] read_data;
        logic read_valid;
        logic alert_n;
        logic alert_oe;
    } core_state_s;

endpackage : dual_temp_monitor_pkg

// *** hw/sample_averager.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dual_temp_monitor_map.svh"

module sample_averager (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire logic [7:0] sample_data,
    output logic [7:0] average,
    output logic average_valid
);

    dual_temp_monitor_pkg::avg_state_s s;
    dual_temp_monitor_pkg::avg_state_s next_s;

    always_comb
    begin
        logic signed [11:0] total;
        total = s.sum + {{4{sample_data[7]}}, sample_data};
        next_s = s;
        next_s.valid = 1'b0;
        if (sample_valid)
        begin
            next_s.count = s.count + 4'h1;
            if (s.count == 4'hF)
            begin
                // arithmetic shift keeps the sign of the sum
                next_s.average = total[11:`AVG_SAMPLES_LOG2];
                next_s.valid = 1'b1;
                next_s.sum = 12'h000;
            end
            else
            begin
                next_s.sum = total;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign average = s.average;
    assign average_valid = s.valid;

endmodule : sample_averager
`default_nettype wire

// *** hw/dual_temp_monitor_core.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dual_temp_monitor_map.svh"

module dual_temp_monitor_core #(
    parameter int unsigned fastest_period_cycles = `FASTEST_CONV_CYCLES,
    // arbitrary neutral identity values
    parameter logic [7:0] maker_id = 8'h5A,
    parameter logic [7:0] die_revision = 8'h01
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_write_valid,
    input wire logic bus_write_first,
    input wire logic [7:0] bus_write_data,
    input wire logic bus_read_req,
    input wire logic alert_response,
    input wire logic sample_valid,
    input wire logic [7:0] sample_data,
    input wire logic sample_open,
    output logic sensor_select,
    output logic sample_request,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic alert_n,
    output logic alert_oe
);

    dual_temp_monitor_pkg::core_state_s s;
    dual_temp_monitor_pkg::core_state_s next_s;

    logic avg_in_valid;
    logic [7:0] avg_value;
    logic avg_valid;

    // signed compare, strict in both directions
    function automatic logic [1:0] limit_trip(
        input logic [7:0] value,
        input logic [7:0] high,
        input logic [7:0] low
    );
        limit_trip[1] = $signed(value) > $signed(high);
        limit_trip[0] = $signed(value) < $signed(low);
    endfunction : limit_trip

    assign avg_in_valid = sample_valid && (s.state == dual_temp_monitor_pkg::st_wait);

    sample_averager averager (
        .sys_clk(sys_clk),
        .rst(rst),
        .sample_valid(avg_in_valid),
        .sample_data(sample_data),
        .average(avg_value),
        .average_valid(avg_valid)
    );

    always_comb
    begin
        logic [4:0] cause;
        logic [31:0] period;
        logic status_read;
        logic [7:0] status;
        next_s = s;
        next_s.sample_request = 1'b0;
        next_s.read_valid = 1'b0;
        cause = {limit_trip(s.local_value, s.local_high, s.local_low),
                 limit_trip(s.remote_value, s.remote_high, s.remote_low),
                 s.remote_open};
        period = 32'(fastest_period_cycles) << (`RATE_CODE_MAX - s.rate[2:0]);
        status_read = bus_read_req && (s.pointer == `ADDR_RD_STATUS);
        status = {s.busy, s.flags, 2'b00};

        // free-running rate timer; frozen in standby
        if (!s.standby)
        begin
            if (s.timer >= period - 32'd1)
            begin
                next_s.timer = 32'h0000_0000;
                next_s.run_pending = 1'b1;
            end
            else
            begin
                next_s.timer = s.timer + 32'd1;
            end
        end

        unique case (s.state)
            dual_temp_monitor_pkg::st_idle:
            begin
                if (s.oneshot_pending || (s.run_pending && !s.standby))
                begin
                    next_s.oneshot_pending = 1'b0;
                    next_s.run_pending = 1'b0;
                    next_s.busy = 1'b1;
                    next_s.remote_sel = 1'b0;
                    next_s.open_seen = 1'b0;
                    next_s.state = dual_temp_monitor_pkg::st_request;
                end
            end
            dual_temp_monitor_pkg::st_request:
            begin
                next_s.sample_request = 1'b1;
                next_s.state = dual_temp_monitor_pkg::st_wait;
            end
            dual_temp_monitor_pkg::st_wait:
            begin
                if (sample_valid)
                begin
                    if (s.remote_sel && sample_open)
                    begin
                        next_s.open_seen = 1'b1;
                    end
                    next_s.state = dual_temp_monitor_pkg::st_settle;
                end
            end
            dual_temp_monitor_pkg::st_settle:
            begin
                // averager answers one cycle after its sixteenth sample
                if (avg_valid)
                begin
                    if (s.remote_sel)
                    begin
                        next_s.remote_value = avg_value;
                        next_s.remote_open = s.open_seen;
                        next_s.busy = 1'b0;
                        next_s.state = dual_temp_monitor_pkg::st_idle;
                    end
                    else
                    begin
                        next_s.local_value = avg_value;
                        next_s.remote_sel = 1'b1;
                        next_s.state = dual_temp_monitor_pkg::st_request;
                    end
                end
                else
                begin
                    next_s.state = dual_temp_monitor_pkg::st_request;
                end
            end
        endcase

        // value registers have no write address at all
        if (bus_write_valid)
        begin
            if (bus_write_first)
            begin
                next_s.pointer = bus_write_data;
            end
            else
            begin
                case (s.pointer)
                    `ADDR_WR_CONFIG:
                    begin
                        next_s.alarm_output_inhibit = bus_write_data[`CONFIG_MASK_BIT];
                        next_s.standby = bus_write_data[`CONFIG_STANDBY_BIT];
                    end
                    `ADDR_WR_RATE:
                    begin
                        next_s.rate = bus_write_data;
                    end
                    `ADDR_WR_LOCAL_HIGH:
                    begin
                        next_s.local_high = bus_write_data;
                    end
                    `ADDR_WR_LOCAL_LOW:
                    begin
                        next_s.local_low = bus_write_data;
                    end
                    `ADDR_WR_REMOTE_HIGH:
                    begin
                        next_s.remote_high = bus_write_data;
                    end
                    `ADDR_WR_REMOTE_LOW:
                    begin
                        next_s.remote_low = bus_write_data;
                    end
                    `ADDR_WR_ONE_SHOT:
                    begin
                        next_s.oneshot_pending = 1'b1;
                    end
                    default:
                    begin
                        // read-only and reserved addresses swallow the byte
                    end
                endcase
            end
        end

        if (bus_read_req)
        begin
            next_s.read_valid = 1'b1;
            case (s.pointer)
                `ADDR_RD_LOCAL: next_s.read_data = s.local_value;
                `ADDR_RD_REMOTE: next_s.read_data = s.remote_value;
                `ADDR_RD_STATUS: next_s.read_data = status;
                `ADDR_RD_CONFIG: next_s.read_data = {s.alarm_output_inhibit, s.standby, 6'h00};
                `ADDR_RD_RATE: next_s.read_data = s.rate;
                `ADDR_RD_LOCAL_HIGH: next_s.read_data = s.local_high;
                `ADDR_RD_LOCAL_LOW: next_s.read_data = s.local_low;
                `ADDR_RD_REMOTE_HIGH: next_s.read_data = s.remote_high;
                `ADDR_RD_REMOTE_LOW: next_s.read_data = s.remote_low;
                `ADDR_RD_MAKER_ID: next_s.read_data = maker_id;
                `ADDR_RD_DIE_REV: next_s.read_data = die_revision;
                default: next_s.read_data = `INVALID_READ;
            endcase
        end

        // a live cause re-sets its flag, so set wins over the read
        for (int i = 0; i < 5; i++)
        begin
            next_s.flags[i] = (s.flags[i] && !status_read) || cause[i];
        end

        if (|s.flags)
        begin
            next_s.alert_latch = 1'b1;
        end
        else if (alert_response && !(|cause))
        begin
            next_s.alert_latch = 1'b0;
        end

        // masking gates the pin only; the latch keeps its state
        next_s.alert_oe = s.alert_latch && !s.alarm_output_inhibit;
        next_s.alert_n = !next_s.alert_oe;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.pointer <= `RESET_POINTER;
            s.local_value <= `RESET_VALUE;
            s.remote_value <= `RESET_VALUE;
            s.rate <= `RESET_RATE;
            s.local_high <= `RESET_HIGH_LIMIT;
            s.local_low <= `RESET_LOW_LIMIT;
            s.remote_high <= `RESET_HIGH_LIMIT;
            s.remote_low <= `RESET_LOW_LIMIT;
            s.state <= dual_temp_monitor_pkg::st_idle;
            s.alert_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign sensor_select = s.remote_sel;
    assign sample_request = s.sample_request;
    assign read_data = s.read_data;
    assign read_valid = s.read_valid;
    assign alert_n = s.alert_n;
    assign alert_oe = s.alert_oe;

endmodule : dual_temp_monitor_core
`default_nettype wire

// *** verification/temp_core_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module temp_core_checker #(
    parameter int unsigned fastest_period_cycles = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_write_valid,
    input wire logic bus_read_req,
    input wire logic alert_response,
    input wire logic sample_valid,
    input wire logic sensor_select,
    input wire logic sample_request,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic alert_n,
    input wire logic alert_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // samples asked so far; bit 4 names the channel
    logic [4:0] n_req;
    always_ff @(posedge sys_clk)
        n_req <= rst ? 5'h00 : n_req + {4'h0, sample_request};
    a_read_answer: assert property (bus_read_req |=> read_valid)
        else $error("read not answered");
    a_read_cause: assert property (read_valid |-> $past(bus_read_req))
        else $error("answer without read");
    a_data_hold: assert property ($changed(read_data) && !$past(rst) |-> read_valid)
        else $error("read data moved");
    a_alert_pin: assert property (alert_n == !alert_oe)
        else $error("alert pin and enable disagree");
    a_request_pulse: assert property (sample_request |=> !sample_request)
        else $error("sample request too long");
    a_sample_gap: assert property (sample_valid |=> !sample_request)
        else $error("request right after sample");
    a_channel_order: assert property (sample_request |-> sensor_select == n_req[4])
        else $error("channel out of turn");
    a_alert_release: assert property ($fell(alert_oe) && !$past(rst) |->
        $past(alert_response, 2) || $past(bus_write_valid, 2))
        else $error("alert released without cause");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=>
        !read_valid && !sample_request && !alert_oe && read_data == 8'h00)
        else $error("outputs not quiet after reset");
    c_read_seen: cover property (read_valid);
    c_alert_set: cover property ($rose(alert_oe));
    c_alert_freed: cover property ($fell(alert_oe));
    c_remote_turn: cover property ($rose(sensor_select));
endmodule : temp_core_checker
bind dual_temp_monitor_core temp_core_checker #(
    .fastest_period_cycles(fastest_period_cycles)
) u_chk (
    .sys_clk, .rst, .bus_write_valid, .bus_read_req, .alert_response, .sample_valid,
    .sensor_select, .sample_request, .read_data, .read_valid, .alert_n, .alert_oe
);
`default_nettype wire

// *** verification/smbus_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    output logic bus_write_valid,
    output logic bus_write_first,
    output logic [7:0] bus_write_data,
    output logic bus_read_req,
    output logic alert_response
);
    initial
    begin
        bus_write_valid = 1'b0;
        bus_write_first = 1'b0;
        bus_write_data = 8'h00;
        bus_read_req = 1'b0;
        alert_response = 1'b0;
    end
    // released data lines show the inverse, never a stale byte
    task automatic point(input logic [7:0] a);
        @(negedge sys_clk);
        bus_write_valid = 1'b1;
        bus_write_first = 1'b1;
        bus_write_data = a;
        @(negedge sys_clk);
        bus_write_valid = 1'b0;
        bus_write_data = ~a;
    endtask : point
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a > 8'h0F)
            return;
        // valid stays up from pointer byte to data byte, no double drive in one step
        @(negedge sys_clk);
        bus_write_valid = 1'b1;
        bus_write_first = 1'b1;
        bus_write_data = a;
        @(negedge sys_clk);
        bus_write_first = 1'b0;
        bus_write_data = d;
        @(negedge sys_clk);
        bus_write_valid = 1'b0;
        bus_write_data = ~d;
    endtask : wr
    // bounded wait; a missing answer comes back unknown
    task automatic rd(input logic [7:0] a, input bit p, output logic [7:0] d);
        int i;
        if (p)
            point(a);
        else
            @(negedge sys_clk);
        bus_read_req = 1'b1;
        @(negedge sys_clk);
        bus_read_req = 1'b0;
        for (i = 0; i < 4 && read_valid !== 1'b1; i++)
            @(negedge sys_clk);
        d = (read_valid === 1'b1) ? read_data : 8'hXX;
    endtask : rd
    task automatic ack;
        @(negedge sys_clk);
        alert_response = 1'b1;
        @(negedge sys_clk);
        alert_response = 1'b0;
    endtask : ack
endmodule : smbus_host_model
`default_nettype wire

// *** verification/test_dual_temp_monitor_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_dual_temp_monitor_core;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    logic sample_open = 1'b0;
    logic [7:0] sample_data = 8'h00;
    logic bus_write_valid, bus_write_first, bus_read_req, alert_response;
    logic sensor_select, sample_request, read_valid, alert_n, alert_oe, op, m, lat;
    logic [7:0] bus_write_data, read_data, lt, rt, el, er, d;
    logic [7:0] lim [4];
    logic [7:0] rv [2:8] = '{8'h00, 8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    logic [4:0] c;
    int seed = 32'hB301;
    int n_fail = 0;
    int samples_checked = 0;
    int n_req = 0;
    int n_pulse = 0;
    int n0, i, k;
    dual_temp_monitor_core #(.fastest_period_cycles(8)) dut (
        .sys_clk, .rst, .bus_write_valid, .bus_write_first, .bus_write_data, .bus_read_req,
        .alert_response, .sample_valid, .sample_data, .sample_open, .sensor_select,
        .sample_request, .read_data, .read_valid, .alert_n, .alert_oe
    );
    smbus_host_model host (
        .sys_clk, .read_data, .read_valid, .bus_write_valid, .bus_write_first,
        .bus_write_data, .bus_read_req, .alert_response
    );
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // samples alternate v and v^1, so the mean floors to v with bit 0 clear
    function automatic logic [7:0] avg16(input logic [7:0] v);
        return {v[7:1], 1'b0};
    endfunction : avg16
    function automatic logic [4:0] trips(input logic [7:0] l, input logic [7:0] r);
        return {$signed(l) > $signed(lim[0]), $signed(l) < $signed(lim[1]),
            $signed(r) > $signed(lim[2]), $signed(r) < $signed(lim[3]), op};
    endfunction : trips
    task automatic widen;
        for (int j = 0; j < 4; j++)
            host.wr(8'h0B + j[7:0], j[0] ? 8'h80 : 8'h7F);
    endtask : widen
    // request pulses seen so far; non-blocking so readers see the count before this pulse
    always @(negedge sys_clk)
        if (sample_request === 1'b1)
            n_pulse <= n_pulse + 1;
    // front end: answers after 0 to 3 cycles
    always @(negedge sys_clk)
        if (sample_request === 1'b1)
        begin
            check({7'h00, sensor_select}, {7'h00, n_req[4]});
            repeat ($unsigned($random(seed)) % 4) @(negedge sys_clk);
            sample_data = (sensor_select ? rt : lt) ^ {7'h00, n_req[0]};
            sample_open = sensor_select & op;
            sample_valid = 1'b1;
            n_req++;
            @(negedge sys_clk);
            sample_valid = 1'b0;
            sample_data = ~sample_data;
        end
    initial
    begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        host.rd(8'h00, 1'b0, d);
        check(d, 8'h00);
        for (i = 2; i < 9; i++)
        begin
            host.rd(i[7:0], 1'b1, d);
            check(d, rv[i]);
        end
        host.wr(8'h09, 8'h40);
        host.wr(8'h00, 8'h55);
        host.rd(8'h00, 1'b1, d);
        check(d, 8'h00);
        host.rd(8'h0B, 1'b1, d);
        check(d, 8'h00);
        host.rd(8'h03, 1'b1, d);
        check(d, 8'h40);
        widen();
        lat = 1'b0;
        $display("register test done");
        for (k = 0; k < 12; k++)
        begin
            lt = k ? 8'($random(seed)) : 8'h80;
            rt = k ? 8'($random(seed)) : 8'h7F;
            op = k > 0 && $random(seed) % 4 == 0;
            m = $random(seed) % 3 == 0;
            el = avg16(lt);
            er = avg16(rt);
            host.wr(8'h09, {m, 7'h40});
            host.wr(8'h0F, 8'hA5);
            host.rd(8'h02, 1'b1, d);
            check({7'h00, d[7]}, 8'h01);
            for (i = 0; i < 150 && d[7] !== 1'b0; i++)
                host.rd(8'h02, 1'b0, d);
            check({7'h00, d[7]}, 8'h00);
            host.rd(8'h00, 1'b1, d);
            check(d, el);
            host.rd(8'h01, 1'b1, d);
            check(d, er);
            for (i = 0; i < 4; i++)
            begin
                lim[i] = (i < 2 ? el : er) + (k ? 8'($random(seed) % 2) : 8'h00);
                host.wr(8'h0B + i[7:0], lim[i]);
            end
            c = trips(el, er);
            lat = lat | (|c);
            host.rd(8'h02, 1'b1, d);
            check(d, {1'b0, c, 2'b00});
            check({7'h00, alert_n}, {7'h00, ~(lat & ~m)});
            check({7'h00, alert_oe}, {7'h00, lat & ~m});
            widen();
            host.rd(8'h02, 1'b1, d);
            check(d, {1'b0, c, 2'b00});
            host.rd(8'h02, 1'b0, d);
            check(d, {5'h00, op, 2'b00});
            check({7'h00, alert_n}, {7'h00, ~(lat & ~m)});
            host.ack();
            lat = lat & op;
            repeat (3) @(negedge sys_clk);
            check({7'h00, alert_n}, {7'h00, ~(lat & ~m)});
        end
        $display("conversion test done");
        n0 = n_req;
        repeat (300) @(negedge sys_clk);
        check(8'(n_req - n0), 8'h00);
        // code 0 is 128 fastest periods of 8 cycles between conversion starts
        host.wr(8'h0A, 8'h00);
        host.wr(8'h09, 8'h00);
        for (i = 0; i < 2100 && !(sample_request === 1'b1 && n_pulse[4:0] == 5'h00); i++)
            @(negedge sys_clk);
        @(negedge sys_clk);
        for (i = 1; i < 2100 && !(sample_request === 1'b1 && n_pulse[4:0] == 5'h00); i++)
            @(negedge sys_clk);
        check(8'(i >> 8), 8'h04);
        check(8'(i), 8'h00);
        $display("rate test done");
        n0 = n_req;
        host.wr(8'h0A, 8'h07);
        host.wr(8'h09, 8'h00);
        for (i = 0; i < 4000 && n_req < n0 + 64; i++)
            @(negedge sys_clk);
        check({7'h00, n_req >= n0 + 64}, 8'h01);
        $display("free run test done");
        finish_test();
    end
endmodule : test_dual_temp_monitor_core
`default_nettype wire
